// >>> logic/lcd_port_pkg.sv
// package: register map, field positions, reset values and carriers for the shared port
package lcd_port_pkg;

    // ****************************************
    // register indices (word addresses)
    // ****************************************
    localparam int          ADDR_W          = 3;
    localparam logic [2:0]  OFS_PIN_LEVEL   = 3'h0;  // pin levels / latch write
    localparam logic [2:0]  OFS_LATCH       = 3'h1;  // output latch
    localparam logic [2:0]  OFS_DIRECTION   = 3'h2;  // direction, 1 = input
    localparam logic [2:0]  OFS_PULLUP_CTRL = 3'h3;  // pull-up control and aux bits
    localparam logic [2:0]  OFS_SEG_ENABLE  = 3'h4;  // segment enables

    // ****************************************
    // field positions
    // ****************************************
    localparam int          BIT_PORT_PU_DIS  = 7;    // this port's pull-up disable
    localparam int          BIT_OTHER_PU_DIS = 6;    // other port's pull-up disable
    localparam int          BIT_THIRD_PU_DIS = 5;    // third port's, stored but reads zero on small package
    localparam int          AUX_W            = 5;    // aux pin bits 4..0

    // ****************************************
    // values after reset
    // ****************************************
    localparam logic [7:0]  RST_LATCH       = 8'h00;
    localparam logic [7:0]  RST_DIRECTION   = 8'hff; // all inputs
    localparam logic [7:0]  RST_PULLUP_CTRL = 8'he0; // all pull-up disables set
    localparam logic [7:0]  RST_SEG_ENABLE  = 8'h00; // all digital
    localparam logic [7:0]  RD_ZERO         = 8'h00;

    // register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } bus_req_t;

    // pin drive bundle
    typedef struct packed {
        logic [7:0] out;   // driven level
        logic [7:0] oe;    // digital drive enable
        logic [7:0] pu;    // weak pull-up enable
        logic [7:0] seg;   // pin handed to segment drive
    } pin_drive_t;

endpackage : lcd_port_pkg

// >>> logic/lcd_shared_gpio_port.sv
// eight-pin general-purpose port shared with lcd segment drives
//
// Notes on behaviour
// - eight pins, each input or output
// - direction and latch kept in registers
// - direction 0 drives latch, 1 is input
// - input pins read back through schmitt buffer
// - reset makes every pin an input
// - weak pull-ups, one global disable bit
// - pull-up off while pin is output
// - reset leaves pull-ups disabled
// - segment enable takes pin, digital off
// - segment bits map one to one
// - small package: bit 5 reads zero
`timescale 1ns/1ns
module lcd_shared_gpio_port
    import lcd_port_pkg::*;
#(
    parameter int  PIN_COUNT   = 8,   // pins on the port
    parameter bit  SMALL_PKG   = 1'b0 // 1 = 64-pin package
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [7:0]       regWdata,
    input  wire logic             regWr,
    input  wire logic             regRd,
    output logic      [7:0]       regRdata,
    // pad side
    input  wire logic [7:0]       portPinIn,
    output logic      [7:0]       portPinOut,
    output logic      [7:0]       portPinOe,
    output logic      [7:0]       portPullupEn,
    output logic      [7:0]       segmentDriveSel,
    // aux pins sharing the pull-up control register
    input  wire logic [AUX_W-1:0] auxPinIn
);

    // ****************************************
    // elaboration check
    // ****************************************
    if (PIN_COUNT != 8) begin : g_bad_width
        $error("lcd_shared_gpio_port supports exactly eight pins");
    end

    // ****************************************
    // register map
    // ****************************************
    // index 0: pin levels on read, output latch on write
    // index 1: output latch, reads back the latch, not the pins
    // index 2: direction, one bit a pin, 1 = input
    // index 3: bit 7 this port's pull-up disable
    //          bits 6..5 other ports' pull-up disables, stored only
    //          bits 4..0 aux pin levels, read-only
    // index 4: segment enables, bit n takes pin n
    // indices 5..7: writes ignored, reads give zero
    //
    // timing: a write takes effect at the edge that samples it;
    // read data stand in the cycle after the strobe, zero otherwise;
    // pin levels pass one sample stage before they can be read
    // hazard: a pin read right after a direction change may still
    // show the level from before the change
    // limitation: the weak pull-up and the segment drive are only
    // selected here; the analog side sits outside the block

    // ****************************************
    // state
    // ****************************************
    bus_req_t   busReq;          // bundled bus request
    pin_drive_t drive;           // bundled pad drive
    logic [7:0] latch_ff;        // output latch
    logic [7:0] direction_ff;    // 1 = input
    logic [2:0] puDisable_ff;    // pull-up disables, bits 7..5
    logic [7:0] segEnable_ff;    // segment enables
    logic [7:0] pinSample_ff;    // sampled pin level
    logic [7:0] nxt_regRdata;    // read mux
    logic [7:0] pullupCtrlView;  // pull-up control as read

    assign busReq = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    // register write decode
    // one comparison shared by every register write
    function automatic logic hit(input bus_req_t r, input logic [ADDR_W-1:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction : hit

    // latch: written from both the port and latch addresses
    // both indices alias one register, but the pin index reads back pin levels,
    // so a read-modify-write of it can smear input levels into the latch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch_ff <= RST_LATCH;
        end else if (hit(busReq, OFS_PIN_LEVEL) || hit(busReq, OFS_LATCH)) begin
            latch_ff <= busReq.wdata;
        end
    end

    // direction register
    // reset leaves every pin an input so nothing drives the board
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            direction_ff <= RST_DIRECTION;
        end else if (hit(busReq, OFS_DIRECTION)) begin
            direction_ff <= busReq.wdata;
        end
    end

    // pull-up disable bits
    // bits 6..5 are stored for the other ports; bit 7 gates this port
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            puDisable_ff <= RST_PULLUP_CTRL[BIT_PORT_PU_DIS:BIT_THIRD_PU_DIS];
        end else if (hit(busReq, OFS_PULLUP_CTRL)) begin
            puDisable_ff <= busReq.wdata[BIT_PORT_PU_DIS:BIT_THIRD_PU_DIS];
        end
    end

    // segment enables
    // a set bit hands the pin to the segment drive at once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            segEnable_ff <= RST_SEG_ENABLE;
        end else if (hit(busReq, OFS_SEG_ENABLE)) begin
            segEnable_ff <= busReq.wdata;
        end
    end

    // input sampling; segment pins read as zero
    // one stage only: inputs are taken as synchronous to clk
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinSample_ff <= RD_ZERO;
        end else begin
            pinSample_ff <= portPinIn & ~segEnable_ff;
        end
    end

    // ****************************************
    // pad drive
    // ****************************************
    // per-pin priority, highest first:
    //   segment enable  - pin belongs to the lcd, no drive, no pull-up
    //   direction 0     - pin drives its latch bit, pull-up off
    //   direction 1     - pin floats, pull-up on unless disabled
    // segment ownership wins over direction, direction over latch
    genvar gi;
    for (gi = 0; gi < 8; gi++) begin : g_pin
        // output only when digital and direction is 0
        assign drive.oe[gi]  = ~segEnable_ff[gi] & ~direction_ff[gi];
        assign drive.out[gi] = latch_ff[gi] & drive.oe[gi];
        // pull-up only for a digital input with global enable
        assign drive.pu[gi]  = ~puDisable_ff[2] & direction_ff[gi]
                               & ~segEnable_ff[gi];
        assign drive.seg[gi] = segEnable_ff[gi];
    end

    assign portPinOut      = drive.out;
    assign portPinOe       = drive.oe;
    assign portPullupEn    = drive.pu;
    assign segmentDriveSel = drive.seg;

    // ****************************************
    // read path
    // ****************************************
    // bit 5 is stored on both packages but hidden on the small one
    // the other two pull-up disable bits have no pads here; they are
    // kept so that software sees back what it wrote
    always_comb begin
        pullupCtrlView = {puDisable_ff[2], puDisable_ff[1],
                          puDisable_ff[0] & ~SMALL_PKG, auxPinIn};
    end

    // read mux on the index alone; the strobe picks the cycle
    always_comb begin
        nxt_regRdata = RD_ZERO;
        case (busReq.addr)
            OFS_PIN_LEVEL:   nxt_regRdata = pinSample_ff;
            OFS_LATCH:       nxt_regRdata = latch_ff;
            OFS_DIRECTION:   nxt_regRdata = direction_ff;
            OFS_PULLUP_CTRL: nxt_regRdata = pullupCtrlView;
            OFS_SEG_ENABLE:  nxt_regRdata = segEnable_ff;
            default:         nxt_regRdata = RD_ZERO;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdata <= RD_ZERO;
        end else if (busReq.rd) begin
            regRdata <= nxt_regRdata;
        end else begin
            regRdata <= RD_ZERO;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    // the properties watch the pad outputs, the read data and the registers;
    // reset-state checks run at the edge where reset is seen low
    property p_out_drive;
        @(posedge clk) disable iff (rst)
        portPinOe == (~direction_ff & ~segEnable_ff);
    endproperty
    a_out_drive: assert property (p_out_drive) else $error("oe mismatch");

    property p_seg_off;
        @(posedge clk) disable iff (rst)
        (segmentDriveSel & (portPinOe | portPullupEn)) == 8'h00;
    endproperty
    a_seg_off: assert property (p_seg_off) else $error("segment pin driven");

    property p_pu_out;
        @(posedge clk) disable iff (rst)
        (portPullupEn & portPinOe) == 8'h00;
    endproperty
    a_pu_out: assert property (p_pu_out) else $error("pull-up on output");

    property p_pu_dis;
        @(posedge clk) disable iff (rst)
        (regWr && regAddr == OFS_PULLUP_CTRL && regWdata[BIT_PORT_PU_DIS])
        |=> portPullupEn == 8'h00;
    endproperty
    a_pu_dis: assert property (p_pu_dis) else $error("pull-up not disabled");

    property p_latch_wr;
        @(posedge clk) disable iff (rst)
        (regWr && regAddr == OFS_PIN_LEVEL) |=> latch_ff == $past(regWdata);
    endproperty
    a_latch_wr: assert property (p_latch_wr) else $error("latch not written");

    property p_rd_in;
        @(posedge clk) disable iff (rst)
        (regRd && regAddr == OFS_PIN_LEVEL && !$past(rst))
        |=> regRdata == ($past(portPinIn, 2) & ~$past(segEnable_ff, 2));
    endproperty
    a_rd_in: assert property (p_rd_in) else $error("pin read wrong");

    property p_small;
        @(posedge clk) disable iff (rst)
        (SMALL_PKG && regRd && regAddr == OFS_PULLUP_CTRL) |=> !regRdata[5];
    endproperty
    a_small: assert property (p_small) else $error("bit 5 not zero");

    property p_reset_state;
        @(posedge clk)
        $fell(rst) |-> direction_ff == RST_DIRECTION && segEnable_ff == RST_SEG_ENABLE
            && portPullupEn == 8'h00;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad reset state");

    // a direction write lands at the edge that samples it
    property p_dir_wr;
        @(posedge clk) disable iff (rst)
        (regWr && regAddr == OFS_DIRECTION) |=> direction_ff == $past(regWdata);
    endproperty
    a_dir_wr: assert property (p_dir_wr) else $error("direction not written");

    // segment bit n of the write selects pin n
    property p_seg_wr;
        @(posedge clk) disable iff (rst)
        (regWr && regAddr == OFS_SEG_ENABLE) |=> segmentDriveSel == $past(regWdata);
    endproperty
    a_seg_wr: assert property (p_seg_wr) else $error("segment map wrong");

    // the latch index writes the same register as the pin index
    property p_latch_alias;
        @(posedge clk) disable iff (rst)
        (regWr && regAddr == OFS_LATCH) |=> latch_ff == $past(regWdata);
    endproperty
    a_latch_alias: assert property (p_latch_alias) else $error("latch alias lost");

    // the latch index reads the latch, whatever the pins show
    property p_latch_rd;
        @(posedge clk) disable iff (rst)
        (regRd && regAddr == OFS_LATCH) |=> regRdata == $past(latch_ff);
    endproperty
    a_latch_rd: assert property (p_latch_rd) else $error("latch read wrong");

    // direction reads back as written
    property p_dir_rd;
        @(posedge clk) disable iff (rst)
        (regRd && regAddr == OFS_DIRECTION) |=> regRdata == $past(direction_ff);
    endproperty
    a_dir_rd: assert property (p_dir_rd) else $error("direction read wrong");

    // with the global disable clear every digital input gets its pull-up
    property p_pu_on;
        @(posedge clk) disable iff (rst)
        !puDisable_ff[2] |-> portPullupEn == (direction_ff & ~segEnable_ff);
    endproperty
    a_pu_on: assert property (p_pu_on) else $error("pull-up missing");

    // the global disable turns all eight off together
    property p_pu_glob;
        @(posedge clk) disable iff (rst)
        puDisable_ff[2] |-> portPullupEn == 8'h00;
    endproperty
    a_pu_glob: assert property (p_pu_glob) else $error("pull-up left on");

    // a segment pin never shows up in the pin level read
    property p_seg_in;
        @(posedge clk) disable iff (rst)
        (regRd && regAddr == OFS_PIN_LEVEL) |=> (regRdata & $past(segEnable_ff, 2)) == 8'h00;
    endproperty
    a_seg_in: assert property (p_seg_in) else $error("segment pin read");

    // pull-ups come out of reset disabled
    property p_reset_pu;
        @(posedge clk)
        $fell(rst) |-> puDisable_ff == RST_PULLUP_CTRL[7:5] && portPullupEn == 8'h00;
    endproperty
    a_reset_pu: assert property (p_reset_pu) else $error("pull-up on after reset");

    // every pin comes out of reset as a digital port pin
    property p_reset_seg;
        @(posedge clk)
        $fell(rst) |-> segmentDriveSel == RST_SEG_ENABLE && latch_ff == RST_LATCH;
    endproperty
    a_reset_seg: assert property (p_reset_seg) else $error("segment on after reset");

    // the full package reads bit 5 back as stored
    property p_small_keep;
        @(posedge clk) disable iff (rst)
        (!SMALL_PKG && regRd && regAddr == OFS_PULLUP_CTRL)
        |=> regRdata[5] == $past(puDisable_ff[0]);
    endproperty
    a_small_keep: assert property (p_small_keep) else $error("bit 5 lost");

    // writes to unmapped indices change nothing
    property p_unmapped_wr;
        @(posedge clk) disable iff (rst)
        (regWr && regAddr > OFS_SEG_ENABLE)
        |=> $stable(latch_ff) && $stable(direction_ff) && $stable(segEnable_ff);
    endproperty
    a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write landed");

    // ****************************************
    // cover points
    // ****************************************
    c_out: cover property (@(posedge clk) disable iff (rst) portPinOe != 8'h00);
    c_seg: cover property (@(posedge clk) disable iff (rst) segmentDriveSel == 8'hff);
    c_pu:  cover property (@(posedge clk) disable iff (rst) portPullupEn != 8'h00);
    c_rd:  cover property (@(posedge clk) disable iff (rst)
        regRd && regAddr == OFS_PIN_LEVEL);
    c_pu_wr: cover property (@(posedge clk) disable iff (rst)
        regWr && regAddr == OFS_PULLUP_CTRL);

endmodule : lcd_shared_gpio_port

// >>> dv/pad_model.sv
// board-side pad model for the shared port pins
`timescale 1ns/1ns
module pad_model (
    // clock
    input  wire logic       clk,
    // port side
    input  wire logic [7:0] pinOut,
    input  wire logic [7:0] pinOe,
    input  wire logic [7:0] pullEn,
    input  wire logic [7:0] segSel,
    // board side
    input  wire logic [7:0] extVal,
    input  wire logic [7:0] extEn,
    output logic      [7:0] padLevel
);
    logic [7:0] floatFf = 8'h55; // undriven pins wander every cycle
    always_ff @(posedge clk) begin
        floatFf <= ~floatFf;
    end
    // port drive first, then board drive, then pull-up; segment pins wander
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (segSel[i]) padLevel[i] = floatFf[i];
            else if (pinOe[i]) padLevel[i] = pinOut[i];
            else if (extEn[i]) padLevel[i] = extVal[i];
            else padLevel[i] = pullEn[i] | floatFf[i];
        end
    end
endmodule : pad_model

// >>> dv/lcd_shared_gpio_port_test.sv
// self-checking bench for the shared lcd port
`timescale 1ns/1ns
module lcd_shared_gpio_port_test;
    import lcd_port_pkg::*;
    localparam bit SMALL = 1'b1;  // small package: bit 5 reads zero
    logic clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic [2:0] regAddr = 3'h0, ua;
    logic [7:0] regWdata = 8'h00, regRdata, pinOut, pinOe, pullEn, segSel, padLevel;
    logic [7:0] extVal = 8'h00, extEn = 8'h00, lat, dir, seg, en, rs, v, xv, m, dFull, rdFull;
    logic [4:0] aux = 5'h0a;
    int n_mismatch = 0, compares = 0;
    always #4 clk = ~clk;
    lcd_shared_gpio_port #(.SMALL_PKG(SMALL)) dut (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .portPinIn(padLevel), .portPinOut(pinOut), .portPinOe(pinOe),
        .portPullupEn(pullEn), .segmentDriveSel(segSel), .auxPinIn(aux));
    pad_model pads (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pullEn(pullEn),
        .segSel(segSel), .extVal(extVal), .extEn(extEn), .padLevel(padLevel));
    // full package copy on the same bus: bit 5 of the pull-up control reads back
    lcd_shared_gpio_port #(.SMALL_PKG(1'b0)) dutFull (.clk(clk), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(rdFull), .portPinIn(padLevel), .portPinOut(), .portPinOe(),
        .portPullupEn(), .segmentDriveSel(), .auxPinIn(aux));
    // ****************************************
    // bus tasks and comparisons
    // ****************************************
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
        d = regRdata;
        dFull = rdFull;
    endtask : rd
    task automatic rc(input logic [2:0] a, input logic [7:0] exp, input string nm);
        logic [7:0] d;
        rd(a, d);
        chk(nm, d, exp);
    endtask : rc
    // pad outputs, looked at off the edge
    task automatic chk_pins(input logic [7:0] oe, out, pu, sg);
        #1 chk("oe", pinOe, oe);
        chk("out", pinOut, out);
        chk("pu", pullEn, pu);
        chk("seg", segSel, sg);
        @(posedge clk);
    endtask : chk_pins
    task automatic do_reset();
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk_pins(8'h00, 8'h00, 8'h00, 8'h00);
        rc(OFS_LATCH, RST_LATCH, "latch");
        rc(OFS_DIRECTION, RST_DIRECTION, "dir");
        rc(OFS_PULLUP_CTRL, {RST_PULLUP_CTRL[7:6], RST_PULLUP_CTRL[5] & ~SMALL, aux}, "puc");
        chk("puc_full", dFull, {RST_PULLUP_CTRL[7:5], aux});
        rc(OFS_SEG_ENABLE, RST_SEG_ENABLE, "sege");
    endtask : do_reset
    task automatic test_done();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // pin read value, undriven input bits taken as one
    function automatic logic [7:0] exp_pin(input logic [7:0] l, d, s, x, e);
        return ~s & ((~d & l) | (d & e & x) | (d & ~e));
    endfunction : exp_pin
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h515f));
        do_reset();
        for (int k = 0; k < 40; k++) begin
            {lat, dir, seg, xv} = $urandom();
            {en, rs} = 16'($urandom());
            if (k == 0) {dir, seg} = 16'h0000;
            if (k == 1) {dir, seg, en, rs} = 32'hff00_0000;
            if (k == 2) seg = 8'hff;
            extEn <= en;
            extVal <= xv;
            aux <= rs[4:0];
            ua = 3'h5 + 3'(k % 3);
            wr(k[0] ? OFS_LATCH : OFS_PIN_LEVEL, lat);
            wr(OFS_DIRECTION, dir);
            wr(OFS_SEG_ENABLE, seg);
            wr(OFS_PULLUP_CTRL, {rs[7:5], 5'h1f});
            wr(ua, ~lat);
            chk_pins(~dir & ~seg, lat & ~dir & ~seg, ~{8{rs[7]}} & dir & ~seg, seg);
            rd(OFS_PIN_LEVEL, v);
            m = ~dir | seg | en | {8{~rs[7]}};
            chk("pins", v & m, exp_pin(lat, dir, seg, xv, en) & m);
            rc(OFS_LATCH, lat, "latch");
            rc(OFS_DIRECTION, dir, "dir");
            rc(OFS_SEG_ENABLE, seg, "sege");
            rc(OFS_PULLUP_CTRL, {rs[7:6], rs[5] & ~SMALL, rs[4:0]}, "puc");
            chk("puc_full", dFull, rs);
            rc(ua, 8'h00, "unmapped");
        end
        do_reset();
        test_done();
    end
endmodule : lcd_shared_gpio_port_test
